/* bench/flash_protect_ctrl_monitor.sv */
// Purpose: port-level checks of the APB slave and the status word
// Assumes: single REF_CLK domain, SRST synchronous active high
// Notes: status relations are judged only at completed STATUS reads
`timescale 1ns/1ps
module flash_protect_ctrl_monitor (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Serial link
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SERIAL_IN,
    input wire logic WRITE_PROTECT_N,
    input wire logic SERIAL_OUT,
    input wire logic SERIAL_OUT_OE
);
    import flash_pkg::*;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    // A completed read of the status word
    logic st_rd;
    assign st_rd = PREADY && !PWRITE && PADDR == STAT_OFS;
    a_ready_next: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready did not follow the first access cycle");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready stood longer than one cycle");
    a_err_unmapped: assert property (PREADY |-> (PSLVERR == (PADDR != CTRL_OFS && PADDR != STAT_OFS)))
        else $error("slave error does not match the address map");
    a_err_zero_data: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_rdata_hold: assert property (!(PSEL && PENABLE) |=> $stable(PRDATA))
        else $error("read data moved outside an access");
    // Output enable must drop once the select has been high a while
    a_oe_idle: assert property (CS_N [*8] |-> !SERIAL_OUT_OE)
        else $error("serial output driven while deselected");
    a_busy_active: assert property (st_rd && PRDATA[0] |-> PRDATA[8])
        else $error("busy while not active");
    a_deep_idle: assert property (st_rd && PRDATA[9] |-> !PRDATA[0])
        else $error("busy while in deep power-down");
    a_puw_block: assert property (st_rd && !PRDATA[10] |-> !PRDATA[0])
        else $error("internal cycle before power-up timer expired");
endmodule
bind flash_protect_ctrl flash_protect_ctrl_monitor mon (.*);

/* bench/serial_flash_write_protect_control_tb_top.sv */
// Purpose: directed test of program, erase and protection control
// Assumes: APB master and SPI master model drive the ports
// Notes: internal cycles are awaited by bounded polls of the status word
`timescale 1ns/1ps
module serial_flash_write_protect_control_tb_top;
    import flash_pkg::*;
    logic REF_CLK = 1'b0;
    logic SRST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic WRITE_PROTECT_N = 1'b1;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, SCK, CS_N, SERIAL_IN, SERIAL_OUT, SERIAL_OUT_OE;
    logic [31:0] r;
    logic e;
    logic [7:0] b;
    int err_count = 0;
    int checked = 0;
    always #2.5 REF_CLK = ~REF_CLK;
    flash_protect_ctrl uut (.REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCK(SCK),
        .CS_N(CS_N), .SERIAL_IN(SERIAL_IN), .WRITE_PROTECT_N(WRITE_PROTECT_N), .SERIAL_OUT(SERIAL_OUT),
        .SERIAL_OUT_OE(SERIAL_OUT_OE));
    spi_master_model u_spi (.sck(SCK), .cs_n(CS_N), .serial_in(SERIAL_IN), .serial_out(SERIAL_OUT));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // One APB transfer; request held until ready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge REF_CLK);
            if (PREADY === 1'b1)
                break;
        end
        if (i == 50)
        begin
            err_count++;
            complete_run();
        end
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task cmd(input logic [47:0] d, input int n);
        u_spi.frame(d, n, b);
    endtask
    task wren;
        cmd({OP_WREN, 40'h0}, 8);
    endtask
    task pp(input logic [8:0] a, input logic [7:0] d);
        cmd({OP_PP, 15'h0, a, d, 8'h00}, 40);
    endtask
    task rd_byte(input logic [8:0] a, input logic [7:0] exp);
        u_spi.frame({OP_READ, 15'h0, a, 16'h0}, 40, b);
        check(32'(b), 32'(exp));
    endtask
    task st(input logic [10:0] exp);
        apb(1'b0, STAT_OFS, 32'h0);
        check(32'(r[10:0]), 32'(exp));
    endtask
    // Polls one status bit until it reads v; a hang ends the run
    task wait_st(input int k, input logic v);
        for (int i = 0; i < 3000; i++)
        begin
            apb(1'b0, STAT_OFS, 32'h0);
            if (r[k] === v)
                return;
        end
        err_count++;
        complete_run();
    endtask
    initial
    begin
        repeat (8) @(posedge REF_CLK);
        SRST <= 1'b0;
        apb(1'b0, CTRL_OFS, 32'h0);
        check(r, 32'(CTRL_RST));
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        check(32'(e), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        check(r, 32'h0);
        st(11'h000);
        wren();
        pp(9'h000, 8'h00);
        wait_st(10, 1'b1);
        rd_byte(9'h000, 8'hFF);
        cmd({OP_WRDI, 40'h0}, 8);
        // Program without the latch, then a two-byte page wrap
        cmd({OP_PP, 15'h0, 9'h0FF, 8'h12, 8'h34}, 48);
        rd_byte(9'h0FF, 8'hFF);
        wren();
        st(11'h402);
        cmd({OP_PP, 15'h0, 9'h0FF, 8'h12, 8'h34}, 48);
        apb(1'b0, STAT_OFS, 32'h0);
        check(32'(r[0]), 32'h1);
        u_spi.frame({OP_RDSR, 40'h0}, 16, b);
        check(32'(b), 32'h03);
        wait_st(0, 1'b0);
        st(11'h400);
        rd_byte(9'h0FF, 8'h12);
        rd_byte(9'h000, 8'h34);
        wren();
        pp(9'h0FF, 8'hF0);
        wait_st(0, 1'b0);
        rd_byte(9'h0FF, 8'h10);
        // Short clock count, then a proper sector erase on the kept latch
        wren();
        cmd({OP_SE, 15'h0, 9'h0FF, 16'h0}, 31);
        st(11'h402);
        rd_byte(9'h0FF, 8'h10);
        cmd({OP_SE, 15'h0, 9'h0FF, 16'h0}, 32);
        wait_st(0, 1'b0);
        rd_byte(9'h0FF, 8'hFF);
        rd_byte(9'h000, 8'h34);
        // Protect the top quarter, four-sector layout
        wren();
        cmd({OP_WRSR, 8'h04, 32'h0}, 16);
        wait_st(0, 1'b0);
        st(11'h404);
        wren();
        pp(9'h180, 8'h00);
        cmd({OP_PP, 15'h0, 9'h17F, 8'h0F, 8'h00}, 48);
        wait_st(0, 1'b0);
        rd_byte(9'h17F, 8'hFF);
        pp(9'h17F, 8'h00);
        wait_st(0, 1'b0);
        rd_byte(9'h180, 8'hFF);
        rd_byte(9'h17F, 8'h00);
        wren();
        cmd({OP_BE, 40'h0}, 8);
        st(11'h406);
        // Eight-sector layout moves the protected area to the top eighth
        apb(1'b1, CTRL_OFS, 32'h1);
        pp(9'h1C0, 8'h00);
        pp(9'h1BF, 8'h00);
        wait_st(0, 1'b0);
        rd_byte(9'h1C0, 8'hFF);
        rd_byte(9'h1BF, 8'h00);
        // Frozen status while the protect pin is low
        wren();
        cmd({OP_WRSR, 8'h80, 32'h0}, 16);
        wait_st(0, 1'b0);
        @(posedge REF_CLK);
        WRITE_PROTECT_N <= 1'b0;
        wren();
        cmd({OP_WRSR, 8'h9C, 32'h0}, 16);
        st(11'h482);
        @(posedge REF_CLK);
        WRITE_PROTECT_N <= 1'b1;
        cmd({OP_WRSR, 8'h00, 32'h0}, 16);
        wait_st(0, 1'b0);
        st(11'h400);
        // Deep power-down ignores modifying commands until release
        cmd({OP_DP, 40'h0}, 8);
        st(11'h600);
        wren();
        cmd({OP_BE, 40'h0}, 8);
        st(11'h600);
        cmd({OP_RES, 40'h0}, 8);
        st(11'h400);
        wren();
        cmd({OP_BE, 40'h0}, 8);
        apb(1'b0, STAT_OFS, 32'h0);
        check(32'(r[8]), 32'h1);
        check(32'(r[0]), 32'h1);
        wait_st(0, 1'b0);
        rd_byte(9'h000, 8'hFF);
        rd_byte(9'h1BF, 8'hFF);
        complete_run();
    end
endmodule

/* bench/spi_master_model.sv */
// Purpose: SPI master in mode 0 that sends one frame per call
// Assumes: link clock of 48 ns, still between frames
// Notes: data line shows the inverse of its last bit when idle
`timescale 1ns/1ps
module spi_master_model (
    // Link pins
    output logic sck,
    output logic cs_n,
    output logic serial_in,
    // Reply
    input wire logic serial_out
);
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end
    // Sends the top n bits of d, MSB first; rx keeps the last 8 bits seen
    task automatic frame(input logic [47:0] d, input int n, output logic [7:0] rx);
        #7;
        cs_n = 1'b0;
        #24;
        for (int i = 0; i < n; i++)
        begin
            serial_in = d[47-i];
            #24;
            sck = 1'b1;
            rx = {rx[6:0], serial_out};
            #24;
            sck = 1'b0;
        end
        #24;
        cs_n = 1'b1;
        serial_in = ~serial_in; // Released line must not look valid
        #48;
    endtask
endmodule

/* hw/flash_pkg.sv */
// Purpose: shared constants and types for the serial flash protect controller
// Assumes: 200 MHz REF_CLK, APB register access, small flip-flop array
// Notes: opcodes and register offsets are local choices
package flash_pkg;
    // Clock and internal cycle times in ns
    localparam int CLK_NS = 5;
    localparam int T_W_NS = 5000;
    localparam int T_PP_NS = 5000;
    localparam int T_SE_NS = 10000;
    localparam int T_BE_NS = 20000;
    localparam int T_PUW_NS = 10000;
    localparam logic [11:0] W_CYC = 12'((T_W_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] PP_CYC = 12'((T_PP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SE_CYC = 12'((T_SE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] BE_CYC = 12'((T_BE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] PUW_CYC = 12'((T_PUW_NS + CLK_NS - 1) / CLK_NS);
    // Array geometry
    localparam int PAGE_BYTES = 256;
    localparam int MEM_BYTES = 512;
    localparam int ADDR_W = 9;
    localparam logic [8:0] PAGE_LIMIT = 9'h100;
    localparam logic [8:0] BCNT_MAX = 9'h1FF;
    localparam logic [7:0] ERASED = 8'hFF;
    // Command opcodes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_SE = 8'hD8;
    localparam logic [7:0] OP_BE = 8'hC7;
    localparam logic [7:0] OP_DP = 8'hB9;
    localparam logic [7:0] OP_RES = 8'hAB;
    // APB map
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic CTRL_RST = 1'b0;
    // Status byte positions
    localparam int SR_LOCK = 7;
    localparam int SR_BP_HI = 4;
    localparam int SR_BP_LO = 2;
    typedef struct packed {
        logic status_write_disable;
        logic [1:0] rsv;
        logic [2:0] block_protect;
        logic write_enable_latch;
        logic write_in_progress;
    } status_t;
    typedef enum {CYC_IDLE, CYC_WRSR, CYC_PROG, CYC_SERASE, CYC_BERASE} cycle_t;
endpackage

/* hw/flash_protect_ctrl.sv */
// Purpose: program, erase and protection control of a small serial flash
// Assumes: SPI pins and write protect pin are asynchronous to REF_CLK
// Notes: behaviour rules follow, one per line
// Notes on behaviour
// [R1] Page program: up to 256 bytes, one page
// [R2] Programming only clears bits
// [R3] Master sends enable, then four-byte header plus data
// [R4] Erase sets sector or whole array to ones
// [R5] Master enables writes before each erase
// [R6] write_in_progress set during every internal cycle
// [R7] Selected device is in active power state
// [R8] Stays active until internal cycle ends
// [R9] Deep power-down held until release command
// [R10] Deep power-down ignores all modifying commands
// [R11] Modifications blocked until power-up timer expires
// [R12] Modifying commands need clock count multiple of eight
// [R13] Modifying commands need write_enable_latch set
// [R14] Protected sectors reject program and erase
// [R15] Write protect pin freezes status register
// [R16] Four-sector protect decode
// [R17] Eight-sector protect decode
// [R18] Bulk erase only with all protect bits zero
// [R19] Sample input on rising, drive output after falling
// [R20] First command needs a chip select falling edge
// [R21] Rejected command changes nothing
// [R22] Latch clears when internal cycle completes
`timescale 1ns/1ps
module flash_protect_ctrl (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Serial link
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SERIAL_IN,
    input wire logic WRITE_PROTECT_N,
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_OE
);
    import flash_pkg::*;

    logic cs_m, cs_s, cs_p, sck_m, sck_s, sck_p, si_m, si_s, wp_m, wp_s;
    logic sck_rise, sck_fall, frame_start, frame_stop;
    logic [7:0] byte_in;
    status_t status;
    // Frame state
    logic armed_q, armed_d, oe_q, oe_d, so_q, so_d;
    logic [2:0] bit_q, bit_d;
    logic [8:0] bcnt_q, bcnt_d, pcnt_q, pcnt_d;
    logic [7:0] sh_q, sh_d, op_q, op_d, tx_q, tx_d, nsr_q, nsr_d;
    logic [23:0] addr_q, addr_d;
    logic [7:0] pbuf_q [PAGE_BYTES], pbuf_d [PAGE_BYTES];
    // Array state
    logic [7:0] mem_q [MEM_BYTES], mem_d [MEM_BYTES];
    cycle_t cyc_q, cyc_d;
    logic [11:0] cnt_q, cnt_d, pu_q, pu_d, dur;
    logic pu_done_q, pu_done_d, we_latch_q, we_latch_d, sr_lock_q, sr_lock_d, deep_q, deep_d;
    logic [2:0] bp_q, bp_d;
    logic [ADDR_W-1:0] tgt_q, tgt_d;
    logic [7:0] psr_q, psr_d;
    logic [8:0] plen_q, plen_d;
    // Register file state
    logic variant_q, variant_d, pready_d, pslverr_d;
    logic [31:0] prdata_d;
    logic busy, can_mod, frozen, tgt_prot;
    logic [8:0] pp_end;
    logic [ADDR_W-1:0] pp_last, prot_addr;

    // Sector index for either density variant
    function automatic logic [2:0] sector_of(input logic [ADDR_W-1:0] a, input logic v);
        sector_of = v ? a[8:6] : {1'b0, a[8:7]};
    endfunction

    // Lowest protected sector; sectors at or above it are read-only
    function automatic logic [3:0] prot_floor(input logic [2:0] bp, input logic v);
        prot_floor = 4'h0;
        if (!v)
        begin
            case (bp[1:0]) // R16
                2'h0: prot_floor = 4'h4;
                2'h1: prot_floor = 4'h3;
                2'h2: prot_floor = 4'h2;
                default: prot_floor = 4'h0;
            endcase
        end
        else if (!bp[2])
        begin
            case (bp[1:0]) // R17
                2'h0: prot_floor = 4'h8;
                2'h1: prot_floor = 4'h7;
                2'h2: prot_floor = 4'h6;
                default: prot_floor = 4'h4;
            endcase
        end
    endfunction

    // Two-stage synchronisers; CS and SCK edges compare the second stage with a third, delayed stage
    always_ff @(posedge REF_CLK)
    begin
        cs_m <= CS_N;
        cs_s <= cs_m;
        cs_p <= cs_s;
        sck_m <= SCK;
        sck_s <= sck_m;
        sck_p <= sck_s;
        si_m <= SERIAL_IN;
        si_s <= si_m;
        wp_m <= WRITE_PROTECT_N;
        wp_s <= wp_m;
    end

    assign sck_rise = ~cs_s & sck_s & ~sck_p; // R19
    assign sck_fall = ~cs_s & ~sck_s & sck_p; // R19
    assign frame_start = ~cs_s & cs_p;
    assign frame_stop = cs_s & ~cs_p;
    assign byte_in = {sh_q[6:0], si_s};
    assign busy = (cyc_q != CYC_IDLE);
    assign status = '{status_write_disable: sr_lock_q, rsv: 2'h0, block_protect: bp_q,
                      write_enable_latch: we_latch_q, write_in_progress: busy}; // R6

    // Serial frame: shift in, count bits and bytes, shift out replies
    always_comb
    begin
        armed_d = armed_q;
        oe_d = oe_q;
        so_d = so_q;
        bit_d = bit_q;
        bcnt_d = bcnt_q;
        pcnt_d = pcnt_q;
        sh_d = sh_q;
        op_d = op_q;
        tx_d = tx_q;
        nsr_d = nsr_q;
        addr_d = addr_q;
        pbuf_d = pbuf_q;
        if (frame_start)
        begin
            armed_d = 1'b1; // R20
            bit_d = 3'h0;
            bcnt_d = 9'h000;
            pcnt_d = 9'h000;
            op_d = 8'h00; // An empty frame must not replay the last opcode
            oe_d = 1'b0;
        end
        if (sck_rise && armed_q)
        begin
            sh_d = byte_in;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
                bcnt_d = (bcnt_q == BCNT_MAX) ? bcnt_q : bcnt_q + 9'h001;
                if (bcnt_q == 9'h000)
                begin
                    op_d = byte_in;
                    if (byte_in == OP_RDSR && !deep_q)
                    begin
                        tx_d = status;
                        oe_d = 1'b1;
                    end
                end
                else if (bcnt_q <= 9'h003)
                begin
                    addr_d = {addr_q[15:0], byte_in};
                    if (bcnt_q == 9'h001)
                        nsr_d = byte_in;
                    if (bcnt_q == 9'h003 && op_q == OP_READ && !deep_q)
                    begin
                        tx_d = mem_q[{addr_q[0], byte_in}];
                        addr_d = {addr_q[15:0], byte_in} + 24'h000001;
                        oe_d = 1'b1;
                    end
                end
                else if (op_q == OP_PP && !busy)
                begin
                    // Bytes past a page wrap onto the buffer start
                    pbuf_d[8'(bcnt_q - 9'h004)] = byte_in; // R1
                    pcnt_d = (pcnt_q == PAGE_LIMIT) ? pcnt_q : pcnt_q + 9'h001; // R1
                end
                else if (op_q == OP_READ)
                begin
                    tx_d = mem_q[addr_q[ADDR_W-1:0]];
                    addr_d = addr_q + 24'h000001;
                end
                if (op_q == OP_RDSR && bcnt_q != 9'h000)
                    tx_d = status; // R6
            end
        end
        if (sck_fall && oe_q)
        begin
            so_d = tx_q[7]; // R19
            tx_d = {tx_q[6:0], 1'b0};
        end
        if (cs_s)
            oe_d = 1'b0;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            armed_q <= 1'b0;
            oe_q <= 1'b0;
            so_q <= 1'b0;
            bit_q <= 3'h0;
            bcnt_q <= 9'h000;
            pcnt_q <= 9'h000;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            tx_q <= 8'h00;
            nsr_q <= 8'h00;
            addr_q <= 24'h000000;
            pbuf_q <= '{default: 8'hFF};
        end
        else
        begin
            armed_q <= armed_d;
            oe_q <= oe_d;
            so_q <= so_d;
            bit_q <= bit_d;
            bcnt_q <= bcnt_d;
            pcnt_q <= pcnt_d;
            sh_q <= sh_d;
            op_q <= op_d;
            tx_q <= tx_d;
            nsr_q <= nsr_d;
            addr_q <= addr_d;
            pbuf_q <= pbuf_d;
        end
    end

    // Acceptance checks: can_mod for every modifying command, frozen for WRSR only
    assign can_mod = (bit_q == 3'h0) && we_latch_q && !deep_q && pu_done_q && !busy; // R12 R13 R10 R11
    assign frozen = sr_lock_q & ~wp_s; // R15
    // A page program can run past its start sector, so its highest byte decides
    assign pp_end = {1'b0, addr_q[7:0]} + pcnt_q - 9'h001;
    assign pp_last = (pp_end > 9'h0FF) ? {addr_q[8], 8'hFF} : {addr_q[8], pp_end[7:0]};
    assign prot_addr = (op_q == OP_PP) ? pp_last : addr_q[ADDR_W-1:0];
    assign tgt_prot = {1'b0, sector_of(prot_addr, variant_q)} >= prot_floor(bp_q, variant_q); // R14

    // Cycle length of the running internal operation
    always_comb
    begin
        case (cyc_q)
            CYC_WRSR: dur = W_CYC;
            CYC_PROG: dur = PP_CYC;
            CYC_SERASE: dur = SE_CYC;
            CYC_BERASE: dur = BE_CYC;
            default: dur = 12'h001;
        endcase
    end

    // Command execution at deselect, then the internal cycle
    always_comb
    begin
        mem_d = mem_q;
        cyc_d = cyc_q;
        cnt_d = cnt_q;
        pu_d = pu_q;
        pu_done_d = pu_done_q;
        we_latch_d = we_latch_q;
        sr_lock_d = sr_lock_q;
        bp_d = bp_q;
        deep_d = deep_q;
        tgt_d = tgt_q;
        psr_d = psr_q;
        plen_d = plen_q;
        if (!pu_done_q)
        begin
            pu_d = pu_q + 12'h001;
            pu_done_d = (pu_q == PUW_CYC - 12'h001); // R11
        end
        // Anything not accepted below leaves the array, latch, status and power bits as they were
        if (frame_stop && armed_q && !busy && bit_q == 3'h0) // R21 R20
        begin
            tgt_d = addr_q[ADDR_W-1:0];
            psr_d = nsr_q;
            plen_d = pcnt_q;
            case (op_q)
                OP_WREN: if (!deep_q && bcnt_q == 9'h001) we_latch_d = 1'b1;
                OP_WRDI: if (!deep_q && bcnt_q == 9'h001) we_latch_d = 1'b0;
                OP_DP: if (bcnt_q == 9'h001) deep_d = 1'b1; // R9
                OP_RES: deep_d = 1'b0; // R9
                OP_WRSR: if (can_mod && bcnt_q == 9'h002 && !frozen) cyc_d = CYC_WRSR; // R15
                OP_PP: if (can_mod && bcnt_q >= 9'h005 && !tgt_prot) cyc_d = CYC_PROG; // R14
                OP_SE: if (can_mod && bcnt_q == 9'h004 && !tgt_prot) cyc_d = CYC_SERASE; // R14
                OP_BE: if (can_mod && bcnt_q == 9'h001 && bp_q == 3'h0) cyc_d = CYC_BERASE; // R18
                default: ;
            endcase
            cnt_d = 12'h000;
        end
        if (busy)
        begin
            cnt_d = cnt_q + 12'h001;
            if (cnt_q == dur - 12'h001)
            begin
                cyc_d = CYC_IDLE;
                we_latch_d = 1'b0; // R22
                case (cyc_q)
                    CYC_WRSR:
                    begin
                        sr_lock_d = psr_q[SR_LOCK];
                        bp_d = {variant_q & psr_q[SR_BP_HI], psr_q[SR_BP_HI-1:SR_BP_LO]};
                    end
                    CYC_PROG:
                        for (int j = 0; j < PAGE_BYTES; j++)
                            if (9'(j) < plen_q)
                                mem_d[{tgt_q[8], tgt_q[7:0] + 8'(j)}] =
                                    mem_q[{tgt_q[8], tgt_q[7:0] + 8'(j)}] & pbuf_q[j]; // R2 R1
                    CYC_SERASE, CYC_BERASE:
                        for (int i = 0; i < MEM_BYTES; i++)
                            if (cyc_q == CYC_BERASE ||
                                sector_of(ADDR_W'(i), variant_q) == sector_of(tgt_q, variant_q))
                                mem_d[i] = ERASED; // R4
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            mem_q <= '{default: 8'hFF};
            cyc_q <= CYC_IDLE;
            cnt_q <= 12'h000;
            pu_q <= 12'h000;
            pu_done_q <= 1'b0;
            we_latch_q <= 1'b0;
            sr_lock_q <= 1'b0;
            bp_q <= 3'h0;
            deep_q <= 1'b0;
            tgt_q <= '0;
            psr_q <= 8'h00;
            plen_q <= 9'h000;
        end
        else
        begin
            mem_q <= mem_d;
            cyc_q <= cyc_d;
            cnt_q <= cnt_d;
            pu_q <= pu_d;
            pu_done_q <= pu_done_d;
            we_latch_q <= we_latch_d;
            sr_lock_q <= sr_lock_d;
            bp_q <= bp_d;
            deep_q <= deep_d;
            tgt_q <= tgt_d;
            psr_q <= psr_d;
            plen_q <= plen_d;
        end
    end

    // APB: one wait state, write lands on the completing edge
    always_comb
    begin
        variant_d = variant_q;
        prdata_d = PRDATA;
        pready_d = PSEL & PENABLE & ~PREADY;
        pslverr_d = 1'b0;
        if (PSEL && PENABLE && !PREADY)
        begin
            case (PADDR)
                CTRL_OFS: prdata_d = {31'h0, variant_q};
                STAT_OFS: prdata_d = {21'h0, pu_done_q, deep_q, ~cs_s | busy, status}; // R7 R8
                default:
                begin
                    prdata_d = 32'h0;
                    pslverr_d = 1'b1;
                end
            endcase
        end
        // Changing density while a cycle runs would retarget it, so such a write is dropped
        if (PSEL && PENABLE && PREADY && PWRITE && PADDR == CTRL_OFS && !busy)
            variant_d = PWDATA[0];
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            variant_q <= CTRL_RST;
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            variant_q <= variant_d;
            PRDATA <= prdata_d;
            PREADY <= pready_d;
            PSLVERR <= pslverr_d;
        end
    end

    assign SERIAL_OUT = so_q;
    assign SERIAL_OUT_OE = oe_q;
endmodule
